// *** verilog/tdm_slice_consts.svh ***
// Purpose: constants for the tdm buffer configuration and underrun register slice
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: register indices are the printed offsets; byte address is four times the index
`ifndef TDM_SLICE_CONSTS_SVH
`define TDM_SLICE_CONSTS_SVH

`define IDX_LOCAL_TO_TDM_XFER      16'h6024
`define IDX_TX_RING_CTRL_BASE      16'h6040
`define IDX_EXT_TO_INT_CTRL_BASE   16'h6042
`define IDX_TX_RING_BUFFER_BASE    16'h6044
`define IDX_RD_UNDERRUN_LOCATION   16'h6046
`define IDX_RD_UNDERRUN_COUNT      16'h6048
`define IDX_SLICE_CONTROL          16'h6050
`define ADDR_BITS                  18
`define ADDR_WORD_LSB              2

`define RST_REG16                  16'h0000
`define RST_SLICE_CONTROL          16'h0000

`define XF_FIRST_SLOT_MSB          6
`define XF_RSVD_BIT                7
`define XF_COUNT_MSB               14
`define XF_COUNT_LSB               8
`define XF_ENABLE_BIT              15

`define LEN_MSB                    3
`define LEN_MAX_CODE               4'h4
`define BASE_MSB                   15
`define BASE_LSB                   4

`define UL_SLOT_MSB                10
`define UL_SLOT_LSB                4
`define UL_STREAM_MSB              3

`define CTL_MEM_XFER_EN_BIT        0
`define CTL_OUT_EN_BIT             1
`define CTL_STREAM_MSB             15
`define CTL_STREAM_LSB             12

`define SLOT_LAST                  7'h7F
`define SLOT_ONE                   7'h01
`define CNT_ONE                    16'h0001
`define ENTRIES_MIN                12'h080

`endif

// *** verilog/tdm_slice_pkg.sv ***
// Purpose: shared types for the tdm register slice
// Assumes: constants come from tdm_slice_consts.svh
// Notes: states are listed without codes
package tdm_slice_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } bus_phase_type;

  typedef struct packed {
    logic [15:0] xfer;
    logic [15:0] ring_ctrl;
    logic [15:0] ext_int;
    logic [15:0] ring_buf;
    logic [15:0] control;
  } cfg_regs_type;

endpackage

// *** verilog/underrun_if.sv ***
// Purpose: carries underrun events and captured state between modules
// Assumes: single clock
// Notes: event is a one-cycle pulse
`timescale 1ns/1ps
interface underrun_if;
  logic        event_pulse;
  logic [6:0]  slot;
  logic [3:0]  stream;
  logic [10:0] location;
  logic [15:0] count;

  modport source (output event_pulse, output slot, output stream, input location, input count);
  modport tracker (input event_pulse, input slot, input stream, output location, output count);
endinterface

// *** verilog/underrun_tracker.sv ***
// Purpose: captures last underrun location and counts underruns
// Assumes: one event per cycle at most
// Notes: counter wraps silently
`timescale 1ns/1ps
`include "tdm_slice_consts.svh"
module underrun_tracker (
  input  wire logic   sys_clk,
  input  wire logic   srst,
  underrun_if.tracker ur
);

  typedef struct packed {
    logic [10:0] location;
    logic [15:0] count;
  } tracker_state_type;

  tracker_state_type state_q;
  tracker_state_type state_d;

  always_comb
  begin
    state_d = state_q;
    if (ur.event_pulse)
    begin
      state_d.location = {ur.slot, ur.stream};
      state_d.count    = state_q.count + `CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign ur.location = state_q.location;
  assign ur.count    = state_q.count;

endmodule // underrun_tracker

// *** verilog/tdm_buffer_config.sv ***
// Purpose: register slice for local-to-tdm insertion, ring structure bases and underrun capture
// Assumes: AHB-Lite slave, zero wait states, sys_clk 100 MHz, srst synchronous
// Notes: insert enable and slot count take effect at the next frame boundary; first slot and stream select apply at once
//
// Notes on behaviour
// - slot count field bits 14:8, minus one
// - insert enable substitutes 1-128 local slots
// - no transfer unless memory transfer enabled
// - inserted bytes driven only with outputs enabled
// - ring control length codes 0-4, 128-2048
// - ring control bits 15:4 give address 20:9
// - ext-int length codes 0-4, 128-2048 entries
// - ext-int bits 15:4 give address 20:9
// - ring buffer bits 15:4 give address 20:9
// - underrun stores slot 10:4, stream 3:0
// - underrun location bits 15:11 read zero
// - 16-bit counter increments per underrun
// - first-slot field picks output slot 0
// - stream select picks output stream
`timescale 1ns/1ps
`include "tdm_slice_consts.svh"
module tdm_buffer_config (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // tdm framing and data
  input  wire logic        frame_start,
  input  wire logic [6:0]  out_slot,
  input  wire logic [3:0]  out_stream,
  input  wire logic [7:0]  receive_reassembly_path,
  input  wire logic [7:0]  local_serial_input,
  input  wire logic        underrun_event,
  input  wire logic [6:0]  underrun_slot,
  input  wire logic [3:0]  underrun_stream,
  output logic      [7:0]  tdm_out_data,
  output logic             tdm_out_drive,
  output logic             local_slot_taken,
  // memory structure configuration
  output logic      [11:0] tx_ring_ctrl_entries,
  output logic      [20:0] tx_ring_ctrl_base_addr,
  output logic      [11:0] ext_int_ctrl_entries,
  output logic      [20:0] ext_int_ctrl_base_addr,
  output logic      [20:0] tx_ring_base_addr
);

  typedef struct packed {
    tdm_slice_pkg::bus_phase_type phase;
    logic [15:0]                  idx;
    tdm_slice_pkg::cfg_regs_type  cfg;
    logic                         ins_enable;
    logic [6:0]                   ins_count;
    logic [31:0]                  hrdata;
    logic [7:0]                   out_data;
    logic                         out_drive;
    logic                         slot_taken;
    logic [11:0]                  ring_entries;
    logic [20:0]                  ring_ctrl_addr;
    logic [11:0]                  ext_entries;
    logic [20:0]                  ext_addr;
    logic [20:0]                  buf_addr;
  } top_state_type;

  top_state_type state_q;
  top_state_type state_d;

  underrun_if ur ();

  assign ur.event_pulse = underrun_event;
  assign ur.slot        = underrun_slot;
  assign ur.stream      = underrun_stream;

  underrun_tracker u_tracker (
    .sys_clk (sys_clk),
    .srst    (srst),
    .ur      (ur)
  );

  // reserved codes decode to zero entries so downstream logic sees no table
  function automatic logic [11:0] length_entries(input logic [3:0] code);
    if (code > `LEN_MAX_CODE)
      length_entries = '0;
    else
      length_entries = `ENTRIES_MIN << code;
  endfunction

  // field at 15:4 becomes address bits 20:9
  function automatic logic [20:0] base_address(input logic [15:0] r);
    base_address = {r[`BASE_MSB:`BASE_LSB], 9'h000};
  endfunction

  function automatic logic [31:0] read_word(input logic [15:0] idx,
                                            input tdm_slice_pkg::cfg_regs_type c,
                                            input logic [10:0] loc,
                                            input logic [15:0] cnt);
    case (idx)
      `IDX_LOCAL_TO_TDM_XFER:    read_word = {16'h0000, c.xfer};
      `IDX_TX_RING_CTRL_BASE:    read_word = {16'h0000, c.ring_ctrl};
      `IDX_EXT_TO_INT_CTRL_BASE: read_word = {16'h0000, c.ext_int};
      `IDX_TX_RING_BUFFER_BASE:  read_word = {16'h0000, c.ring_buf};
      `IDX_RD_UNDERRUN_LOCATION: read_word = {21'h000000, loc};
      `IDX_RD_UNDERRUN_COUNT:    read_word = {16'h0000, cnt};
      `IDX_SLICE_CONTROL:        read_word = {16'h0000, c.control};
      default:                   read_word = 32'h00000000;
    endcase
  endfunction

  logic        mem_xfer_en;
  logic        outputs_en;
  logic [6:0]  first_slot;
  logic [6:0]  slot_offset;
  logic        in_window;
  logic        stream_hit;

  always_comb
  begin
    mem_xfer_en = state_q.cfg.control[`CTL_MEM_XFER_EN_BIT];
    outputs_en  = state_q.cfg.control[`CTL_OUT_EN_BIT];
    first_slot  = state_q.cfg.xfer[`XF_FIRST_SLOT_MSB:0];
    slot_offset = out_slot - first_slot;
    in_window   = (slot_offset <= state_q.ins_count);
    stream_hit  = (out_stream == state_q.cfg.control[`CTL_STREAM_MSB:`CTL_STREAM_LSB]);
  end

  always_comb
  begin
    state_d = state_q;

    // address phase capture; data phase handled next cycle
    state_d.phase = tdm_slice_pkg::BUS_IDLE;
    if (hsel && hready && htrans[1])
    begin
      state_d.idx   = haddr[`ADDR_BITS-1:`ADDR_WORD_LSB];
      state_d.phase = hwrite ? tdm_slice_pkg::BUS_WRITE : tdm_slice_pkg::BUS_READ;
      if (!hwrite)
        state_d.hrdata = read_word(haddr[`ADDR_BITS-1:`ADDR_WORD_LSB], state_q.cfg, ur.location, ur.count);
    end

    case (state_q.phase)
      tdm_slice_pkg::BUS_WRITE:
      begin
        case (state_q.idx)
          `IDX_LOCAL_TO_TDM_XFER:    state_d.cfg.xfer      = hwdata[15:0];
          `IDX_TX_RING_CTRL_BASE:    state_d.cfg.ring_ctrl = hwdata[15:0];
          `IDX_EXT_TO_INT_CTRL_BASE: state_d.cfg.ext_int   = hwdata[15:0];
          `IDX_TX_RING_BUFFER_BASE:  state_d.cfg.ring_buf  = hwdata[15:0];
          `IDX_SLICE_CONTROL:        state_d.cfg.control   = hwdata[15:0];
          default:                   state_d.cfg           = state_q.cfg;
        endcase
      end
      tdm_slice_pkg::BUS_READ:  state_d.cfg = state_q.cfg;
      tdm_slice_pkg::BUS_IDLE:  state_d.cfg = state_q.cfg;
      default:                  state_d.cfg = state_q.cfg;
    endcase

    if (frame_start)
    begin
      state_d.ins_enable = state_q.cfg.xfer[`XF_ENABLE_BIT];
      state_d.ins_count  = state_q.cfg.xfer[`XF_COUNT_MSB:`XF_COUNT_LSB];
    end

    state_d.ring_entries   = length_entries(state_q.cfg.ring_ctrl[`LEN_MSB:0]);
    state_d.ring_ctrl_addr = base_address(state_q.cfg.ring_ctrl);
    state_d.ext_entries    = length_entries(state_q.cfg.ext_int[`LEN_MSB:0]);
    state_d.ext_addr       = base_address(state_q.cfg.ext_int);
    state_d.buf_addr       = base_address(state_q.cfg.ring_buf);

    // substitution for the current slot
    state_d.slot_taken = state_q.ins_enable && mem_xfer_en && stream_hit && in_window;
    state_d.out_data   = state_d.slot_taken ? local_serial_input : receive_reassembly_path;
    state_d.out_drive  = mem_xfer_en && outputs_en;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_q               <= '0;
      state_q.phase         <= tdm_slice_pkg::BUS_IDLE;
      state_q.cfg.xfer      <= `RST_REG16;
      state_q.cfg.ring_ctrl <= `RST_REG16;
      state_q.cfg.ext_int   <= `RST_REG16;
      state_q.cfg.ring_buf  <= `RST_REG16;
      state_q.cfg.control   <= `RST_SLICE_CONTROL;
    end
    else
      state_q <= state_d;
  end

  assign hrdata                 = state_q.hrdata;
  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign tdm_out_data           = state_q.out_data;
  assign tdm_out_drive          = state_q.out_drive;
  assign local_slot_taken       = state_q.slot_taken;
  assign tx_ring_ctrl_entries   = state_q.ring_entries;
  assign tx_ring_ctrl_base_addr = state_q.ring_ctrl_addr;
  assign ext_int_ctrl_entries   = state_q.ext_entries;
  assign ext_int_ctrl_base_addr = state_q.ext_addr;
  assign tx_ring_base_addr      = state_q.buf_addr;

endmodule // tdm_buffer_config

// *** bench/tdm_buffer_config_checker.sv ***
// Purpose: port assertions for tdm_buffer_config
// Assumes: zero-wait slave, registered outputs lag one cycle
// Notes: bound from the bench top file
`timescale 1ns/1ps
`include "tdm_slice_consts.svh"
module tdm_buffer_config_checker (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  receive_reassembly_path,
  input wire logic [7:0]  local_serial_input,
  input wire logic        underrun_event,
  input wire logic [6:0]  underrun_slot,
  input wire logic [3:0]  underrun_stream,
  input wire logic [7:0]  tdm_out_data,
  input wire logic        local_slot_taken,
  input wire logic [20:0] tx_ring_ctrl_base_addr,
  input wire logic [20:0] ext_int_ctrl_base_addr,
  input wire logic [20:0] tx_ring_base_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence take(logic [31:0] a, logic w);
    hsel && hready && htrans[1] && hwrite == w && haddr == a;
  endsequence
  sequence ur_then_read;
    underrun_event ##1 take({14'h0, `IDX_RD_UNDERRUN_LOCATION, 2'h0}, 1'b0);
  endsequence
  // data phase stores the word, the output register adds one more cycle
  property p_base(logic [31:0] a, logic [20:0] o);
    take(a, 1'b1) ##1 1'b1 |-> ##2 o == {$past(hwdata[15:4], 2), 9'h000};
  endproperty
  a_ring_ctrl_base: assert property (p_base({14'h0, `IDX_TX_RING_CTRL_BASE, 2'h0}, tx_ring_ctrl_base_addr))
    else $error("ring control base differs from written field");
  a_ext_int_base: assert property (p_base({14'h0, `IDX_EXT_TO_INT_CTRL_BASE, 2'h0}, ext_int_ctrl_base_addr))
    else $error("ext-int base differs from written field");
  a_ring_buf_base: assert property (p_base({14'h0, `IDX_TX_RING_BUFFER_BASE, 2'h0}, tx_ring_base_addr))
    else $error("ring buffer base differs from written field");
  a_local_data: assert property (!$past(srst) && local_slot_taken |-> tdm_out_data == $past(local_serial_input))
    else $error("substituted slot does not carry local byte");
  a_path_data: assert property (!$past(srst) && !local_slot_taken |-> tdm_out_data == $past(receive_reassembly_path))
    else $error("plain slot does not carry reassembly byte");
  a_ur_location: assert property (ur_then_read |-> ##1 hrdata == {21'h0, $past(underrun_slot, 2), $past(underrun_stream, 2)})
    else $error("underrun location read back wrong");
  a_read_upper: assert property (take(haddr, 1'b0) |=> hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered with error");
endmodule // tdm_buffer_config_checker

// *** bench/tdm_buffer_config_tb_top.sv ***
// Purpose: self-checking bench for tdm_buffer_config
// Assumes: zero-wait AHB-Lite slave, outputs lag registers one cycle
// Notes: random stimulus from a fixed xorshift seed
`timescale 1ns/1ps
`include "tdm_slice_consts.svh"
module tdm_buffer_config_tb_top;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        frame_start = 1'b0;
  logic        underrun_event = 1'b0;
  logic        hreadyout, hresp, tdm_out_drive, local_slot_taken, exp_taken, exp_drive;
  logic        exp_ok = 1'b0, mon_on = 1'b0, ur_on = 1'b0, lat_en = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rs = 32'h06AE;
  // own stream for the sequencer; rs moves every edge and cannot be read back later
  logic [31:0] r0 = 32'h06AE;
  logic [6:0]  out_slot = 7'h0, underrun_slot = 7'h0, lat_cnt = 7'h0;
  logic [3:0]  out_stream = 4'h0, underrun_stream = 4'h0;
  logic [7:0]  reasm = 8'h0, local_in = 8'h0, tdm_out_data, exp_data;
  logic [10:0] last_loc = 11'h0;
  logic [11:0] ring_n, ext_n;
  logic [20:0] ring_a, ext_a, buf_a;
  logic [15:0] xfer_sh = 16'h0, ctl_sh = 16'h0, d;
  logic [15:0] rst_idx [7] = '{`IDX_LOCAL_TO_TDM_XFER, `IDX_TX_RING_CTRL_BASE, `IDX_EXT_TO_INT_CTRL_BASE,
                               `IDX_RD_UNDERRUN_LOCATION, `IDX_RD_UNDERRUN_COUNT, `IDX_SLICE_CONTROL, 16'h6030};
  logic [15:0] rw_idx [6] = '{`IDX_LOCAL_TO_TDM_XFER, `IDX_TX_RING_CTRL_BASE, `IDX_EXT_TO_INT_CTRL_BASE,
                              `IDX_TX_RING_BUFFER_BASE, `IDX_RD_UNDERRUN_COUNT, 16'h6030};
  int          n_errors = 0, num_checks = 0, ur_n = 0, cycles = 0, k0;

  tdm_buffer_config tdm_buffer_config_inst (
    .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frame_start(frame_start), .out_slot(out_slot), .out_stream(out_stream), .receive_reassembly_path(reasm),
    .local_serial_input(local_in), .underrun_event(underrun_event), .underrun_slot(underrun_slot),
    .underrun_stream(underrun_stream), .tdm_out_data(tdm_out_data), .tdm_out_drive(tdm_out_drive),
    .local_slot_taken(local_slot_taken), .tx_ring_ctrl_entries(ring_n), .tx_ring_ctrl_base_addr(ring_a),
    .ext_int_ctrl_entries(ext_n), .ext_int_ctrl_base_addr(ext_a), .tx_ring_base_addr(buf_a));

  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [11:0] ents(input logic [3:0] c);
    return (c <= 4'h4) ? (12'h080 << c) : 12'h000;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one single transfer; shadows move by nba so same-edge readers see the old value
  task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] dat);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {14'h0, i, 2'h0};
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= dat;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
    if (w && i == `IDX_LOCAL_TO_TDM_XFER) xfer_sh <= dat[15:0];
    if (w && i == `IDX_SLICE_CONTROL) ctl_sh <= dat[15:0];
  endtask

  always @(posedge sys_clk)
  begin
    rs = xs(rs);
    out_slot        <= out_slot + 7'h01;
    frame_start     <= (out_slot == 7'h7F);
    out_stream      <= rs[8] ? ctl_sh[15:12] : rs[3:0];
    reasm           <= rs[23:16];
    local_in        <= rs[31:24];
    underrun_event  <= ur_on;
    underrun_slot   <= rs[15:9];
    underrun_stream <= rs[7:4];
    if (underrun_event === 1'b1)
    begin
      ur_n++;
      last_loc = {underrun_slot, underrun_stream};
    end
    cycles++;
    if (cycles > 90000)
    begin
      n_errors++;
      stop_test();
    end
  end

  // expectation from this edge is compared at the next one
  always @(posedge sys_clk)
  begin
    if (mon_on && exp_ok)
    begin
      chk(local_slot_taken, exp_taken);
      chk(tdm_out_data, exp_data);
      chk(tdm_out_drive, exp_drive);
    end
    if (frame_start)
    begin
      lat_en  = xfer_sh[15];
      lat_cnt = xfer_sh[14:8];
    end
    exp_ok    = !frame_start && !srst;
    exp_taken = lat_en && ctl_sh[0] && out_stream == ctl_sh[15:12] && (out_slot - xfer_sh[6:0]) <= lat_cnt;
    exp_data  = exp_taken ? local_in : reasm;
    exp_drive = ctl_sh[0] && ctl_sh[1];
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    for (int k = 0; k < 7; k++)
    begin
      bus(1'b0, rst_idx[k], 32'h0);
      chk(rd, 32'h0);
    end
    for (int k = 0; k < 24; k++)
    begin
      r0 = xs(r0);
      d  = r0[15:0] & ((k % 6 == 0) ? 16'hFF7F : (k % 6 == 3) ? 16'hFFF0 : 16'hFFFF);
      bus(1'b1, rw_idx[k % 6], {r0[31:16], d});
      bus(1'b0, rw_idx[k % 6], 32'h0);
      chk(rd, (k % 6 > 3) ? 32'h0 : {16'h0, d});
    end
    for (int c = 0; c < 16; c++)
    begin
      r0 = xs(r0);
      bus(1'b1, `IDX_TX_RING_CTRL_BASE, {16'h0, r0[15:4], c[3:0]});
      bus(1'b1, `IDX_EXT_TO_INT_CTRL_BASE, {16'h0, r0[31:20], 4'hF - c[3:0]});
      bus(1'b1, `IDX_TX_RING_BUFFER_BASE, {16'h0, r0[27:16], 4'h0});
      repeat (2) @(posedge sys_clk);
      chk(ring_n, ents(c[3:0]));
      chk(ext_n, ents(4'hF - c[3:0]));
      chk(ring_a, {r0[15:4], 9'h000});
      chk(ext_a, {r0[31:20], 9'h000});
      chk(buf_a, {r0[27:16], 9'h000});
    end
    ur_on = 1'b1;
    repeat (5) @(posedge sys_clk);
    ur_on = 1'b0;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, `IDX_RD_UNDERRUN_LOCATION, 32'h0);
    chk(rd, {21'h0, last_loc});
    bus(1'b0, `IDX_RD_UNDERRUN_COUNT, 32'h0);
    chk(rd, {16'h0, ur_n[15:0]});
    // a full lap of the counter must land back on the same low bits
    k0    = ur_n + 65536;
    ur_on = 1'b1;
    bus(1'b0, `IDX_RD_UNDERRUN_LOCATION, 32'h0);
    while (ur_n < k0) @(posedge sys_clk);
    ur_on = 1'b0;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, `IDX_RD_UNDERRUN_COUNT, 32'h0);
    chk(rd, {16'h0, ur_n[15:0]});
    mon_on = 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      r0 = xs(r0);
      bus(1'b1, `IDX_SLICE_CONTROL, {16'h0, r0[15:12], 10'h0, r0[1], r0[0] | (k[1:0] != 2'h0)});
      bus(1'b1, `IDX_LOCAL_TO_TDM_XFER, {16'h0, r0[31] | k[0], 2'h0, (k == 1) ? 5'h1F : (k == 0) ? 5'h00 : r0[20:16],
                                         1'b0, r0[30:24]});
      repeat (100) @(posedge sys_clk);
    end
    stop_test();
  end
endmodule // tdm_buffer_config_tb_top

bind tdm_buffer_config tdm_buffer_config_checker tdm_buffer_config_checker_inst (
  .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .receive_reassembly_path(receive_reassembly_path), .local_serial_input(local_serial_input),
  .underrun_event(underrun_event), .underrun_slot(underrun_slot), .underrun_stream(underrun_stream),
  .tdm_out_data(tdm_out_data), .local_slot_taken(local_slot_taken), .tx_ring_ctrl_base_addr(tx_ring_ctrl_base_addr),
  .ext_int_ctrl_base_addr(ext_int_ctrl_base_addr), .tx_ring_base_addr(tx_ring_base_addr));
